// ### smd_pkg.sv
// Package with constants and carriers for the signed multiply/divide sequencer.
package smd_pkg;
  localparam int WORD = 16;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] STEP_LOAD = 5'h10;
  localparam logic [WORD-1:0] ZERO_WORD = 16'h0000;
  localparam logic [2*WORD-1:0] ZERO_DWORD = 32'h00000000;

  typedef enum logic [2:0] {
    SMD_IDLE = 3'b001,
    SMD_MUL = 3'b010,
    SMD_DIV = 3'b100
  } smd_state_t;

  typedef struct packed {
    logic isDiv;
    logic [2*WORD-1:0] dividend;
    logic [WORD-1:0] opA;
    logic [WORD-1:0] opB;
  } smd_req_t;

  typedef struct packed {
    logic [2*WORD-1:0] product;
    logic [WORD-1:0] quotient;
    logic [WORD-1:0] remainder;
    logic overflow;
  } smd_res_t;
endpackage : smd_pkg

// ### smd_addsub.sv
// Adder/subtractor used by both multiply and divide steps.
module smd_addsub
  import smd_pkg::*;
#(
  parameter int W = 32
) (
  input wire logic [W-1:0] a,
  input wire logic [W-1:0] b,
  input wire logic sub,
  output logic [W-1:0] y
);
  assign y = sub ? a - b : a + b;
endmodule : smd_addsub

// ### smd_sequencer.sv
// Sequential signed multiply and non-restoring divide engine.
// Function
// - Multiply takes one add, subtract or skip step per multiplier bit.
// - Multiplicand multiples are formed by shifting it left one place per step.
// - Signed operands multiply directly with no final correction.
// - Equal current and previous multiplier bits leave the product unchanged.
// - Current 0, previous 1 adds; current 1, previous 0 subtracts.
// - The multiplicand is aligned to the bit weight before combining.
// - Division returns quotient and a consistently signed remainder.
// - An unrepresentable quotient is flagged as overflow and delivered with doneValid and a zero quotient and remainder.
// - Division starts with the largest divisor multiple, then smaller ones.
// - Subtraction keeping the original sign sets the quotient bit.
// - Sign change clears the bit; no restore; later steps add.
// - During adding, the bit sets only when the original sign returns.
// - Previous multiplier bit starts at 0; multiplier shifts right each step.
// - Differing signs add the shifted divisor, equal signs subtract it.
// - Quotient bit is set when remainder and divisor signs agree.
module smd_sequencer
  import smd_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clkEn,
  input wire logic startValid,
  output logic startReady,
  input wire smd_req_t request,
  output logic busy,
  output logic doneValid,
  output smd_res_t result
);
  // ****************************************************************
  // State and datapath registers
  // ****************************************************************
  smd_state_t state;
  logic [CNT_W-1:0] stepCounter;
  logic [WORD-1:0] multiplier;
  logic prevBit;
  logic [2*WORD-1:0] mcand;
  logic [2*WORD-1:0] acc;
  logic [2*WORD-1:0] divisorSh;
  logic [WORD-1:0] quot;
  logic dividendSign;
  logic [2*WORD-1:0] addA;
  logic [2*WORD-1:0] addB;
  logic addSub;
  logic [2*WORD-1:0] sum;
  logic mulStep;
  logic divSub;
  logic qBit;
  logic ovfNow;
  logic [WORD-1:0] quotRaw;
  logic remFix;

  assign startReady = (state == SMD_IDLE);
  assign busy = !startReady;

  // Multiply: skip on equal bits, add on 0/1, subtract on 1/0.
  assign mulStep = multiplier[0] ^ prevBit;
  // Divide: subtract when remainder and divisor signs agree.
  assign divSub = (acc[2*WORD-1] == divisorSh[2*WORD-1]);

  always_comb begin
    addA = acc;
    addB = ZERO_DWORD;
    addSub = 1'b0;
    if (state == SMD_MUL) begin
      addB = mulStep ? mcand : ZERO_DWORD;
      addSub = multiplier[0];
    end else if (state == SMD_DIV) begin
      addB = divisorSh;
      addSub = divSub;
    end
  end

  smd_addsub #(.W(2*WORD)) uAddSub (
    .a(addA),
    .b(addB),
    .sub(addSub),
    .y(sum)
  );

  // Set when the new remainder sign matches the divisor sign; zero remainder counts as matching a positive divisor.
  assign qBit = (sum[2*WORD-1] == divisorSh[2*WORD-1]);

  // A last remainder of opposite sign to the divisor means the stored bits sit one unit below the true quotient.
  assign quotRaw = {quot[WORD-2:0], qBit} + {{(WORD-1){1'b0}}, !qBit};
  // Pull back a remainder of the wrong sign, or one as large as the divisor, so exact divisions end at zero.
  assign remFix = (sum != ZERO_DWORD) && ((sum[2*WORD-1] != dividendSign) || (sum == divisorSh) ||
    (sum == ZERO_DWORD - divisorSh));

  // The quotient fits when the dividend magnitude is below the divisor magnitude times 2^(n-1), plus one divisor when negative.
  // A zero divisor always overflows, which is the intended trade for keeping the check simple.
  function automatic logic div_overflow(input logic [2*WORD-1:0] dvd, input logic [WORD-1:0] dvs);
    logic [2*WORD:0] mDvd;
    logic [WORD:0] mDvs;
    logic negQ;
    logic [2*WORD:0] lim;
    mDvd = dvd[2*WORD-1] ? {1'b0, -dvd} : {1'b0, dvd};
    mDvs = dvs[WORD-1] ? {1'b0, -dvs} : {1'b0, dvs};
    negQ = dvd[2*WORD-1] ^ dvs[WORD-1];
    lim = {mDvs, ZERO_WORD};
    if (mDvs == '0) begin
      return 1'b1;
    end
    // Allowed magnitude of the quotient is 2^(n-1)-1, or 2^(n-1) when negative.
    lim = (lim >> 1) + (negQ ? {mDvs, ZERO_WORD} >> (WORD) : '0);
    return mDvd >= lim;
  endfunction : div_overflow

  assign ovfNow = div_overflow(request.dividend, request.opB);

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state <= SMD_IDLE;
      stepCounter <= '0;
      multiplier <= ZERO_WORD;
      prevBit <= 1'b0;
      mcand <= ZERO_DWORD;
      acc <= ZERO_DWORD;
      divisorSh <= ZERO_DWORD;
      quot <= ZERO_WORD;
      dividendSign <= 1'b0;
      doneValid <= 1'b0;
      result <= '0;
    end else if (clkEn) begin
      doneValid <= 1'b0;
      unique case (state)
        SMD_IDLE: begin
          if (startValid) begin
            stepCounter <= STEP_LOAD;
            prevBit <= 1'b0;
            quot <= ZERO_WORD;
            if (request.isDiv) begin
              if (ovfNow) begin
                result.overflow <= 1'b1;
                result.quotient <= ZERO_WORD;
                result.remainder <= ZERO_WORD;
                doneValid <= 1'b1;
              end else begin
                acc <= request.dividend;
                dividendSign <= request.dividend[2*WORD-1];
                // Largest multiple first: divisor weighted by 2^(n-1).
                divisorSh <= {{1{request.opB[WORD-1]}}, request.opB, {(WORD-1){1'b0}}};
                state <= SMD_DIV;
              end
            end else begin
              multiplier <= request.opB;
              mcand <= {{WORD{request.opA[WORD-1]}}, request.opA};
              acc <= ZERO_DWORD;
              state <= SMD_MUL;
            end
          end
        end
        SMD_MUL: begin
          acc <= sum;
          prevBit <= multiplier[0];
          multiplier <= {multiplier[WORD-1], multiplier[WORD-1:1]};
          mcand <= {mcand[2*WORD-2:0], 1'b0};
          stepCounter <= stepCounter - 5'h01;
          if (stepCounter == 5'h01) begin
            result.product <= sum;
            result.overflow <= 1'b0;
            doneValid <= 1'b1;
            state <= SMD_IDLE;
          end
        end
        SMD_DIV: begin
          acc <= sum;
          quot <= {quot[WORD-2:0], qBit};
          divisorSh <= {divisorSh[2*WORD-1], divisorSh[2*WORD-1:1]};
          stepCounter <= stepCounter - 5'h01;
          if (stepCounter == 5'h01) begin
            // Remainder correction: a misplaced remainder is moved by one divisor and the quotient follows.
            if (remFix) begin
              if (sum[2*WORD-1] == divisorSh[2*WORD-1]) begin
                result.remainder <= sum[WORD-1:0] - divisorSh[WORD-1:0];
                result.quotient <= quotRaw + 16'h0001;
              end else begin
                result.remainder <= sum[WORD-1:0] + divisorSh[WORD-1:0];
                result.quotient <= quotRaw - 16'h0001;
              end
            end else begin
              result.remainder <= sum[WORD-1:0];
              result.quotient <= quotRaw;
            end
            result.overflow <= 1'b0;
            doneValid <= 1'b1;
            state <= SMD_IDLE;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_mul_skip: assert property (@(posedge mclk) disable iff (!resetn)
    (clkEn && state == SMD_MUL && !mulStep) |=> acc == $past(acc))
    else $error("multiply step changed product on equal bits");
  chk_mul_shift: assert property (@(posedge mclk) disable iff (!resetn)
    (clkEn && state == SMD_MUL) |=> mcand == {$past(mcand[2*WORD-2:0]), 1'b0})
    else $error("multiplicand not doubled");
  chk_prev_zero: assert property (@(posedge mclk) disable iff (!resetn)
    (clkEn && startValid && startReady && !request.isDiv) |=> !prevBit)
    else $error("previous bit not cleared at start");
  chk_mul_len: assert property (@(posedge mclk) disable iff (!resetn)
    (clkEn && startValid && startReady && !request.isDiv) ##1 clkEn [*8] ##1 clkEn [*8] |=> doneValid)
    else $error("multiply did not finish in word width steps");
  chk_cnt_load: assert property (@(posedge mclk) disable iff (!resetn)
    (clkEn && startValid && startReady && !(request.isDiv && ovfNow)) |=> stepCounter == STEP_LOAD)
    else $error("step counter not loaded");
  chk_div_op: assert property (@(posedge mclk) disable iff (!resetn)
    (clkEn && state == SMD_DIV) |=> acc == (($past(acc[2*WORD-1]) == $past(divisorSh[2*WORD-1])) ?
      $past(acc) - $past(divisorSh) : $past(acc) + $past(divisorSh)))
    else $error("divide step direction wrong");
  chk_div_qbit: assert property (@(posedge mclk) disable iff (!resetn)
    (clkEn && state == SMD_DIV && stepCounter != 5'h01) |=> quot[0] == (acc[2*WORD-1] == $past(divisorSh[2*WORD-1])))
    else $error("quotient bit mismatches sign agreement");
  chk_ovf_flag: assert property (@(posedge mclk) disable iff (!resetn)
    (clkEn && startValid && startReady && request.isDiv && ovfNow) |=> doneValid && result.overflow)
    else $error("overflow not reported");
  chk_rem_sign: assert property (@(posedge mclk) disable iff (!resetn)
    (clkEn && state == SMD_DIV && stepCounter == 5'h01) |=>
      (result.remainder == ZERO_WORD) || (result.remainder[WORD-1] == $past(dividendSign)))
    else $error("remainder sign differs from dividend");
endmodule : smd_sequencer

// ### smd_host_model.sv
// Host model that loads operands into the sequencer and collects each result.
module smd_host_model
  import smd_pkg::*;
(
  input wire logic mclk,
  input wire logic startReady,
  input wire logic doneValid,
  input wire smd_res_t result,
  output logic startValid,
  output smd_req_t request
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    startValid = 1'b0;
    request = '0;
  end
  // The strobe may stay up for extra cycles after acceptance; those requests must be ignored.
  // A released request shows the inverse pattern so stale operands never look valid.
  task automatic run(input smd_req_t r, input int extra, output int lat, output smd_res_t res);
    int n;
    n = 0;
    @(posedge mclk);
    #1;
    startValid = 1'b1;
    request = r;
    while (startReady !== 1'b1 && n < 50) begin
      @(posedge mclk);
      #1;
      n++;
    end
    @(posedge mclk);
    #1;
    request = ~r;
    lat = 0;
    while (doneValid !== 1'b1 && lat < 60) begin
      if (lat >= extra) startValid = 1'b0;
      @(posedge mclk);
      #1;
      lat++;
    end
    startValid = 1'b0;
    res = result;
  endtask : run
endmodule : smd_host_model

// ### tb_signed_mul_div_sequencer.sv
// Self-checking bench for the signed multiply/divide sequencer.
module tb_signed_mul_div_sequencer;
  import smd_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    smd_req_t req;
    smd_res_t exp;
  } smd_row_t;
  localparam smd_row_t ROWS [12] = '{
    {1'h0, 32'h0, 16'h0005, 16'h0003, 32'h0000000F, 32'h0, 1'h0},
    {1'h1, 32'h00000011, 16'h0, 16'h0005, 32'h0, 32'h00030002, 1'h0},
    {1'h1, 32'h00010000, 16'h0, 16'h0001, 32'h0, 32'h0, 1'h1},
    {1'h0, 32'h0, 16'hFFFF, 16'h0007, 32'hFFFFFFF9, 32'h0, 1'h0},
    {1'h1, 32'hFFFFFFEF, 16'h0, 16'h0005, 32'h0, 32'hFFFDFFFE, 1'h0},
    {1'h1, 32'h00000005, 16'h0, 16'h0000, 32'h0, 32'h0, 1'h1},
    {1'h1, 32'h00000011, 16'h0, 16'hFFFB, 32'h0, 32'hFFFD0002, 1'h0},
    {1'h1, 32'hFFFF8000, 16'h0, 16'h0001, 32'h0, 32'h80000000, 1'h0},
    {1'h1, 32'h00008000, 16'h0, 16'hFFFF, 32'h0, 32'h80000000, 1'h0},
    {1'h0, 32'h0, 16'h8000, 16'h8000, 32'h40000000, 32'h0, 1'h0},
    {1'h0, 32'h0, 16'h7FFF, 16'h8000, 32'hC0008000, 32'h0, 1'h0},
    {1'h1, 32'hFFFFFFF6, 16'h0, 16'h0005, 32'h0, 32'hFFFE0000, 1'h0}};
  logic mclk, resetn, clkEn, startValid, startReady, busy, doneValid;
  smd_req_t request;
  smd_res_t result, res;
  int lat, failures, compares, i;
  smd_sequencer DUT (.mclk(mclk), .resetn(resetn), .clkEn(clkEn), .startValid(startValid),
    .startReady(startReady), .request(request), .busy(busy), .doneValid(doneValid), .result(result));
  smd_host_model host (.mclk(mclk), .startReady(startReady), .doneValid(doneValid), .result(result),
    .startValid(startValid), .request(request));
  task automatic chk(input string name, input logic [80:0] exp, input logic [80:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic give_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    resetn = 1'b0;
    clkEn = 1'b1;
    failures = 0;
    compares = 0;
    repeat (2) @(posedge mclk);
    #1;
    chk("idle flags", 3'h4, {startReady, busy, doneValid});
    chk("reset result", 81'h0, result);
    resetn = 1'b1;
    for (i = 0; i < 12; i++) begin
      host.run(ROWS[i].req, 0, lat, res);
      chk("latency", ROWS[i].exp.overflow ? 32'h0 : 32'h10, lat);
      chk("overflow", ROWS[i].exp.overflow, res.overflow);
      if (ROWS[i].req.isDiv) begin
        chk("quotient", ROWS[i].exp.quotient, res.quotient);
        chk("remainder", ROWS[i].exp.remainder, res.remainder);
      end else begin
        chk("product", ROWS[i].exp.product, res.product);
      end
    end
    // ******************** Requests held up while busy ********************
    host.run(ROWS[1].req, 4, lat, res);
    chk("busy latency", 32'h10, lat);
    chk("busy quotient", ROWS[1].exp.quotient, res.quotient);
    lat = 0;
    for (i = 0; i < 20; i++) begin
      @(posedge mclk);
      #1;
      lat += (doneValid === 1'b1);
    end
    chk("stray done", 32'h0, lat);
    // ******************** Clock enable freeze ********************
    fork
      host.run(ROWS[0].req, 0, lat, res);
      begin
        repeat (4) @(posedge mclk);
        #1;
        clkEn = 1'b0;
        repeat (4) @(posedge mclk);
        #1;
        clkEn = 1'b1;
      end
    join
    chk("frozen latency", 32'h14, lat);
    chk("frozen product", ROWS[0].exp.product, res.product);
    give_verdict();
  end
endmodule : tb_signed_mul_div_sequencer
